// file: core/abs_restore_pkg.sv
package abs_restore_pkg;

  // ***************************************************
  // Timing
  // ***************************************************
  localparam int CLK_HZ         = 10_000_000;
  localparam int SERVO_OFF_MS   = 20;
  localparam int SERVO_OFF_CYC  = SERVO_OFF_MS * (CLK_HZ / 1000);
  localparam int CLEAR_PULSE_US = 10;
  localparam int CLEAR_CYC      = (CLEAR_PULSE_US * (CLK_HZ / 1000) + 999) / 1000;

  // ***************************************************
  // Data layout and limits
  // ***************************************************
  localparam int POS_W       = 32;
  localparam int PAIR_W      = 2;
  localparam int FB_W        = 16;
  localparam int RANGE_SHIFT = 15;
  localparam int FIFO_DEPTH  = 4;
  localparam int WIDE_W      = 49;
  localparam logic signed [WIDE_W-1:0] ADDR_MIN = -49'sh0000_8000_0000;
  localparam logic signed [WIDE_W-1:0] ADDR_MAX = 49'sh0000_7fff_ffff;
  localparam logic [POS_W-1:0] FEED_RESET = 32'h0000_0000;

  // ***************************************************
  // Pin groups, fixed order
  // ***************************************************
  typedef struct packed {
    logic servo_on_line;
    logic transfer_mode_line;
    logic transfer_request_line;
  } abs_out_t;

  typedef struct packed {
    logic transfer_data_low;
    logic transfer_data_high;
    logic transfer_data_ready;
  } abs_in_t;

  typedef enum {
    ST_IDLE,
    ST_SERVO_OFF,
    ST_REQ,
    ST_RELEASE,
    ST_DRAIN,
    ST_CHECK
  } restore_state_t;

endpackage

// file: core/pair_fifo.sv
`timescale 1ns/1ns
module pair_fifo #(
  parameter int WIDTH = 2,
  parameter int DEPTH = 4
) (
  input  wire logic             clk_i,
  input  wire logic             arst_n_i,
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic      [WIDTH-1:0] out_data_o
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);
  localparam logic [AW-1:0] LAST_IDX = AW'(DEPTH - 1);

  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW-1:0]    wr_reg, wr_next, rd_reg, rd_next;
  logic [CW-1:0]    cnt_reg, cnt_next;
  logic             push, pop;

  assign in_ready_o  = (cnt_reg != FULL_CNT);
  assign out_valid_o = (cnt_reg != '0);
  assign out_data_o  = mem_reg[rd_reg];
  assign push        = in_valid_i && in_ready_o;
  assign pop         = out_valid_o && out_ready_i;

  always_comb begin
    wr_next  = wr_reg;
    rd_next  = rd_reg;
    cnt_next = cnt_reg;
    if (push) begin
      wr_next = (wr_reg == LAST_IDX) ? '0 : wr_reg + 1'b1;
    end
    if (pop) begin
      rd_next = (rd_reg == LAST_IDX) ? '0 : rd_reg + 1'b1;
    end
    if (push && !pop) begin
      cnt_next = cnt_reg + 1'b1;
    end else if (pop && !push) begin
      cnt_next = cnt_reg - 1'b1;
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      wr_reg  <= '0;
      rd_reg  <= '0;
      cnt_reg <= '0;
    end else begin
      wr_reg  <= wr_next;
      rd_reg  <= rd_next;
      cnt_reg <= cnt_next;
    end
  end

  always_ff @(posedge clk_i) begin
    if (push) begin
      mem_reg[wr_reg] <= in_data_i;
    end
  end

endmodule

// file: core/absolute_position_transfer.sv
`timescale 1ns/1ns
module absolute_position_transfer
  import abs_restore_pkg::*;
#(
  parameter int SERVO_OFF_CYCLES = SERVO_OFF_CYC,
  parameter int CLEAR_CYCLES     = CLEAR_CYC,
  parameter int WORD_W           = POS_W
) (
  input  wire logic                                clk_i,
  input  wire logic                                arst_n_i,
  input  wire logic                                servo_enable_i,
  input  wire logic                                restore_start_i,
  input  wire logic                                load_stall_i,
  input  wire logic [abs_restore_pkg::FB_W-1:0]    fb_pulses_i,
  input  wire logic                                origin_reached_i,
  input  wire logic                                count2_mode_i,
  input  wire logic                                manual_origin_i,
  input  wire logic signed [abs_restore_pkg::WIDE_W-1:0] target_i,
  input  wire logic                                endless_feed_i,
  input  wire abs_restore_pkg::abs_in_t            abs_in_i,
  output abs_restore_pkg::abs_out_t                abs_out_o,
  output logic                                     dev_clear_o,
  output logic                                     dev_clear_gp_o,
  output logic [WORD_W-1:0]                        current_feed_o,
  output logic                                     position_valid_o,
  output logic                                     restore_busy_o,
  output logic                                     restore_done_o,
  output logic                                     restore_error_o,
  output logic                                     move_allowed_o
);
  import abs_restore_pkg::*;

  localparam int PAIRS = WORD_W / PAIR_W;
  localparam int PCW   = $clog2(PAIRS + 1);
  localparam int OCW   = $clog2(SERVO_OFF_CYCLES + 1);
  localparam int CCW   = $clog2(CLEAR_CYCLES + 1);
  localparam logic [PCW-1:0] PAIRS_N  = PCW'(PAIRS);
  localparam logic [OCW-1:0] OFF_LAST = OCW'(SERVO_OFF_CYCLES - 1);
  localparam logic [CCW-1:0] CLR_N    = CCW'(CLEAR_CYCLES);

  // ***************************************************
  // State
  // ***************************************************
  restore_state_t        state_reg, state_next;
  abs_out_t              out_reg, out_next;
  logic [OCW-1:0]        off_cnt_reg, off_cnt_next;
  logic [PCW-1:0]        sent_reg, sent_next;
  logic [PCW-1:0]        got_reg, got_next;
  logic [WORD_W-1:0]     word_reg, word_next;
  logic [WORD_W-1:0]     feed_reg, feed_next;
  logic                  valid_reg, valid_next;
  logic                  done_reg, done_next;
  logic                  err_reg, err_next;
  logic                  origin_reg, origin_next;
  logic [CCW-1:0]        clr_cnt_reg, clr_cnt_next;
  logic                  gp_reg, gp_next;
  logic                  move_reg, move_next;

  logic                  fifo_in_valid, fifo_in_ready;
  logic                  fifo_out_valid, fifo_out_ready;
  logic [PAIR_W-1:0]     fifo_out_data;
  logic signed [WIDE_W-1:0] span, lim_lo, lim_hi, pos_wide;

  // ***************************************************
  // Pair buffer
  // ***************************************************
  // Lower bit from first data line, upper from second
  assign fifo_in_valid  = (state_reg == ST_REQ) && out_reg.transfer_request_line &&
                          abs_in_i.transfer_data_ready;
  assign fifo_out_ready = !load_stall_i && (got_reg != PAIRS_N);

  pair_fifo #(
    .WIDTH (PAIR_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk_i       (clk_i),
    .arst_n_i    (arst_n_i),
    .in_valid_i  (fifo_in_valid),
    .in_ready_o  (fifo_in_ready),
    .in_data_i   ({abs_in_i.transfer_data_high, abs_in_i.transfer_data_low}),
    .out_valid_o (fifo_out_valid),
    .out_ready_i (fifo_out_ready),
    .out_data_o  (fifo_out_data)
  );

  // ***************************************************
  // Range limits
  // ***************************************************
  // Span is feedback pulses per revolution times 32768
  assign span     = WIDE_W'(signed'({1'b0, fb_pulses_i})) <<< RANGE_SHIFT;
  assign lim_lo   = -span;
  assign lim_hi   = span - 49'sh1;
  assign pos_wide = WIDE_W'(signed'(word_reg));

  // ***************************************************
  // Restoration sequencer
  // ***************************************************
  always_comb begin
    state_next   = state_reg;
    out_next     = out_reg;
    off_cnt_next = off_cnt_reg;
    sent_next    = sent_reg;
    got_next     = got_reg;
    word_next    = word_reg;
    feed_next    = feed_reg;
    valid_next   = valid_reg;
    done_next    = 1'b0;
    err_next     = 1'b0;
    out_next.servo_on_line = servo_enable_i && (state_reg != ST_SERVO_OFF);
    if (fifo_out_valid && fifo_out_ready) begin
      word_next = {fifo_out_data, word_reg[WORD_W-1:PAIR_W]};
      got_next  = got_reg + 1'b1;
    end
    case (state_reg)
      ST_IDLE: begin
        out_next.transfer_mode_line    = 1'b0;
        out_next.transfer_request_line = 1'b0;
        // Origin must be set first
        if (restore_start_i && origin_reg) begin
          state_next   = ST_SERVO_OFF;
          out_next.transfer_mode_line = 1'b1;
          out_next.servo_on_line      = 1'b0;
          off_cnt_next = '0;
          sent_next    = '0;
          got_next     = '0;
          valid_next   = 1'b0;
        end
      end
      ST_SERVO_OFF: begin
        // Servo-on held off during the window
        out_next.servo_on_line = 1'b0;
        off_cnt_next = off_cnt_reg + 1'b1;
        if (off_cnt_reg == OFF_LAST) begin
          state_next = ST_REQ;
          out_next.servo_on_line = servo_enable_i;
        end
      end
      ST_REQ: begin
        // Request only with room to buffer the pair
        if (!out_reg.transfer_request_line) begin
          out_next.transfer_request_line = fifo_in_ready;
        end else if (abs_in_i.transfer_data_ready && fifo_in_ready) begin
          out_next.transfer_request_line = 1'b0;
          sent_next  = sent_reg + 1'b1;
          state_next = ST_RELEASE;
        end
      end
      ST_RELEASE: begin
        if (!abs_in_i.transfer_data_ready) begin
          state_next = (sent_reg == PAIRS_N) ? ST_DRAIN : ST_REQ;
        end
      end
      ST_DRAIN: begin
        if (got_next == PAIRS_N) begin
          out_next.transfer_mode_line = 1'b0;
          state_next = ST_CHECK;
        end
      end
      ST_CHECK: begin
        state_next = ST_IDLE;
        if (pos_wide >= lim_lo && pos_wide <= lim_hi) begin
          feed_next  = word_reg;
          valid_next = 1'b1;
          done_next  = 1'b1;
        end else begin
          err_next   = 1'b1;
        end
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state_reg   <= ST_IDLE;
      out_reg     <= '0;
      off_cnt_reg <= '0;
      sent_reg    <= '0;
      got_reg     <= '0;
      word_reg    <= '0;
      feed_reg    <= FEED_RESET;
      valid_reg   <= 1'b0;
      done_reg    <= 1'b0;
      err_reg     <= 1'b0;
    end else begin
      state_reg   <= state_next;
      out_reg     <= out_next;
      off_cnt_reg <= off_cnt_next;
      sent_reg    <= sent_next;
      got_reg     <= got_next;
      word_reg    <= word_next;
      feed_reg    <= feed_next;
      valid_reg   <= valid_next;
      done_reg    <= done_next;
      err_reg     <= err_next;
    end
  end

  // ***************************************************
  // Origin setting and move gate
  // ***************************************************
  always_comb begin
    origin_next  = origin_reg;
    clr_cnt_next = clr_cnt_reg;
    gp_next      = gp_reg;
    move_next    = 1'b0;
    // Clear pulse at the origin, or wired output in count-2
    if (clr_cnt_reg != '0) begin
      clr_cnt_next = clr_cnt_reg - 1'b1;
      if (clr_cnt_reg == CCW'(1)) begin
        origin_next = 1'b1;
      end
    end else if (!count2_mode_i && origin_reached_i) begin
      clr_cnt_next = CLR_N;
    end
    if (count2_mode_i && manual_origin_i) begin
      gp_next     = 1'b1;
      origin_next = 1'b1;
    end
    // Address, pulse range and feed kind
    if (valid_reg && !endless_feed_i &&
        target_i >= ADDR_MIN && target_i <= ADDR_MAX &&
        target_i >= lim_lo && target_i <= lim_hi) begin
      move_next = 1'b1;
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      origin_reg  <= 1'b0;
      clr_cnt_reg <= '0;
      gp_reg      <= 1'b0;
      move_reg    <= 1'b0;
    end else begin
      origin_reg  <= origin_next;
      clr_cnt_reg <= clr_cnt_next;
      gp_reg      <= gp_next;
      move_reg    <= move_next;
    end
  end

  // ***************************************************
  // Outputs
  // ***************************************************
  // Sole driver of the reserved pin groups
  assign abs_out_o        = out_reg;
  assign dev_clear_o      = (clr_cnt_reg != '0);
  assign dev_clear_gp_o   = gp_reg;
  assign current_feed_o   = feed_reg;
  assign position_valid_o = valid_reg;
  assign restore_busy_o   = (state_reg != ST_IDLE);
  assign restore_done_o   = done_reg;
  assign restore_error_o  = err_reg;
  assign move_allowed_o   = move_reg;

  // ***************************************************
  // Assertions
  // ***************************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);

  a_req_in_mode: assert property (
    abs_out_o.transfer_request_line |-> abs_out_o.transfer_mode_line)
    else $error("request raised outside transfer mode");

  a_servo_off_window: assert property (
    $rose(abs_out_o.transfer_mode_line) |-> !abs_out_o.servo_on_line [*8])
    else $error("servo-on not held off at restore start");

  a_req_drop_on_ready: assert property (
    abs_out_o.transfer_request_line && abs_in_i.transfer_data_ready && fifo_in_ready
    |=> !abs_out_o.transfer_request_line)
    else $error("request not dropped after ready");

  a_start_needs_origin: assert property (
    $rose(abs_out_o.transfer_mode_line) |-> $past(origin_reg))
    else $error("restore started without origin set");

  a_clear_pulse_len: assert property (
    $rose(dev_clear_o) |-> dev_clear_o [*8])
    else $error("deviation clear pulse too short");

  a_move_needs_valid: assert property (
    !position_valid_o |=> !move_allowed_o)
    else $error("move allowed without restored position");

  a_done_loads_feed: assert property (
    restore_done_o |-> position_valid_o && current_feed_o == $past(word_reg))
    else $error("feed value not loaded on completion");

  a_error_range: assert property (
    restore_error_o |-> !position_valid_o &&
      ($past(pos_wide) < $past(lim_lo) || $past(pos_wide) > $past(lim_hi)))
    else $error("range error without range violation");

  a_endless_refused: assert property (
    endless_feed_i |=> !move_allowed_o)
    else $error("endless feed allowed");

  c_restore_done:  cover property (restore_done_o);
  c_restore_error: cover property (restore_error_o);
  c_fifo_full:     cover property (!fifo_in_ready && abs_out_o.transfer_mode_line);
  c_move_allowed:  cover property ($rose(move_allowed_o));

endmodule

// file: verif/servo_amp_model.sv
`timescale 1ns/1ns
module servo_amp_model
  import abs_restore_pkg::*;
(
  input  wire logic                      clk_i,
  input  wire logic                      arst_n_i,
  input  wire abs_restore_pkg::abs_out_t ctl_i,
  input  wire logic [31:0]               pos_i,
  input  wire logic [3:0]                delay_i,
  output abs_restore_pkg::abs_in_t       abs_o
);
  import abs_restore_pkg::*;

  // ***************************************************
  // Pair sender, answer after delay_i extra cycles
  // ***************************************************
  logic [4:0] idx;
  logic [3:0] wait_cnt;
  logic [1:0] last;
  logic [1:0] pair;

  assign pair = pos_i[2*idx[3:0] +: 2];

  always @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      idx      <= '0;
      wait_cnt <= '0;
      last     <= '0;
      abs_o    <= '0;
    end else if (!ctl_i.transfer_mode_line) begin
      idx                       <= '0;
      wait_cnt                  <= '0;
      abs_o.transfer_data_ready <= 1'b0;
      abs_o.transfer_data_low   <= ~last[0];
      abs_o.transfer_data_high  <= ~last[1];
    end else if (ctl_i.transfer_request_line != abs_o.transfer_data_ready) begin
      if (wait_cnt < delay_i) begin
        wait_cnt <= wait_cnt + 4'h1;
      end else begin
        wait_cnt <= '0;
        if (ctl_i.transfer_request_line) begin
          abs_o.transfer_data_ready <= 1'b1;
          abs_o.transfer_data_low   <= pair[0];
          abs_o.transfer_data_high  <= pair[1];
          last                      <= pair;
        end else begin
          abs_o.transfer_data_ready <= 1'b0;
          abs_o.transfer_data_low   <= ~last[0];
          abs_o.transfer_data_high  <= ~last[1];
          idx                       <= idx + 5'h01;
        end
      end
    end
  end
endmodule

// file: verif/testbench.sv
`timescale 1ns/1ns
module testbench;
  import abs_restore_pkg::*;

  // ***************************************************
  // Clock, stimulus, observed outputs
  // ***************************************************
  logic                     clk     = 1'b0;
  logic                     arst_n  = 1'b0;
  logic                     en      = 1'b1;
  logic                     start   = 1'b0;
  logic                     stall   = 1'b0;
  logic                     origin  = 1'b0;
  logic                     c2      = 1'b0;
  logic                     man     = 1'b0;
  logic                     endless = 1'b0;
  logic [FB_W-1:0]          fb      = 16'h2000;
  logic signed [WIDE_W-1:0] target  = '0;
  logic [31:0]              pos     = '0;
  logic [3:0]               dly     = '0;
  abs_in_t                  amp_in;
  abs_out_t                 ctl;
  logic                     clr, gp, valid, busy, done, err, move;
  logic [31:0]              feed;
  int                       mismatches = 0;
  int                       n_compared = 0;
  int                       off_cnt    = 0;

  always #50 clk = ~clk;

  always @(negedge clk) begin
    if (busy === 1'b1 && ctl.servo_on_line === 1'b0) off_cnt++;
  end

  absolute_position_transfer #(.SERVO_OFF_CYCLES(16), .CLEAR_CYCLES(8)) dut (
    .clk_i(clk), .arst_n_i(arst_n), .servo_enable_i(en), .restore_start_i(start),
    .load_stall_i(stall), .fb_pulses_i(fb), .origin_reached_i(origin),
    .count2_mode_i(c2), .manual_origin_i(man), .target_i(target),
    .endless_feed_i(endless), .abs_in_i(amp_in), .abs_out_o(ctl), .dev_clear_o(clr),
    .dev_clear_gp_o(gp), .current_feed_o(feed), .position_valid_o(valid),
    .restore_busy_o(busy), .restore_done_o(done), .restore_error_o(err),
    .move_allowed_o(move));

  servo_amp_model amp (
    .clk_i(clk), .arst_n_i(arst_n), .ctl_i(ctl), .pos_i(pos), .delay_i(dly),
    .abs_o(amp_in));

  // ***************************************************
  // Shared tasks
  // ***************************************************
  task automatic check(input logic [63:0] seen, input logic [63:0] exp, input string what);
    n_compared++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t %s seen %h exp %h", $time, what, seen, exp);
    end
  endtask

  task automatic give_verdict();
    if (mismatches == 0 && n_compared > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic wait_end();
    for (int i = 0; i < 3000; i++) begin
      cyc(1);
      if (done === 1'b1 || err === 1'b1) return;
    end
    mismatches++;
    $display("MISMATCH t=%0t restore never ended", $time);
    give_verdict();
  endtask

  // ***************************************************
  // Scenarios
  // ***************************************************
  task automatic t_restore(input logic [31:0] p, input logic [3:0] d, input logic st,
                           input logic ok);
    pos     = p;
    dly     = d;
    start   = 1'b1;
    off_cnt = 0;
    cyc(1);
    start = 1'b0;
    stall = st;
    if (st) begin
      cyc(80);
      check(ctl.transfer_request_line, 1'b0, "request while fifo full");
      check(busy, 1'b1, "busy while stalled");
      stall = 1'b0;
    end
    wait_end();
    check(done, ok, "done pulse");
    check(err, !ok, "error pulse");
    check(valid, ok, "position valid");
    if (ok) check(feed, p, "restored feed");
    check(ctl.transfer_mode_line, 1'b0, "mode released");
    check(off_cnt, 16, "servo off window");
    check(ctl.servo_on_line, en, "servo on after restore");
    cyc(2);
  endtask

  task automatic t_origin();
    int n;
    n      = 0;
    origin = 1'b1;
    cyc(1);
    origin = 1'b0;
    for (int i = 0; i < 20; i++) begin
      if (clr === 1'b1) n++;
      cyc(1);
    end
    check(n, 8, "clear pulse width");
  endtask

  task automatic t_move(input logic [15:0] f, input logic signed [48:0] t, input logic e,
                        input logic exp);
    fb      = f;
    target  = t;
    endless = e;
    cyc(2);
    check(move, exp, "move gate");
  endtask

  // ***************************************************
  // Main sequence
  // ***************************************************
  initial begin
    repeat (8) @(posedge clk);
    #1;
    check(ctl, 3'h0, "outputs in reset");
    check({clr, gp, valid, busy, done, err, move}, 7'h00, "flags in reset");
    arst_n = 1'b1;
    start  = 1'b1;
    cyc(3);
    check(busy, 1'b0, "start without origin");
    start = 1'b0;
    t_move(16'h2000, 49'sh0, 1'b0, 1'b0);
    t_origin();
    t_restore(32'h0123_4567, 4'h0, 1'b0, 1'b1);
    t_restore(32'h1000_0000, 4'h0, 1'b0, 1'b0);
    t_restore(32'hf000_0000, 4'h3, 1'b1, 1'b1);
    t_restore(32'h0fff_ffff, 4'h1, 1'b0, 1'b1);
    t_move(16'h2000, 49'sh0000_0fff_ffff, 1'b0, 1'b1);
    t_move(16'h2000, 49'sh0000_1000_0000, 1'b0, 1'b0);
    t_move(16'h2000, -49'sh0000_1000_0000, 1'b0, 1'b1);
    t_move(16'h2000, -49'sh0000_1000_0001, 1'b0, 1'b0);
    t_move(16'h4000, 49'sh0000_1fff_ffff, 1'b0, 1'b1);
    t_move(16'hffff, 49'sh0000_8000_0000, 1'b0, 1'b0);
    t_move(16'h2000, 49'sh0, 1'b1, 1'b0);
    c2  = 1'b1;
    man = 1'b1;
    cyc(1);
    man = 1'b0;
    check(gp, 1'b1, "wired clear output");
    arst_n = 1'b0;
    #1;
    check({valid, gp, move}, 3'h0, "state after second reset");
    cyc(2);
    arst_n = 1'b1;
    start  = 1'b1;
    cyc(3);
    check(busy, 1'b0, "origin lost at reset");
    check(valid, 1'b0, "no position after reset");
    start = 1'b0;
    cyc(2);
    give_verdict();
  end
endmodule
